/* File: design/smp_ctrl.sv */
// Sleep mode control, clock gating, reset pin and port pin control.
`include "smp_regs.svh"

// Behaviour
// - Five software-selected modes gate distinct units.
// - Idle halts processor; memory, timers, serial, interrupts run.
// - Power-down stops oscillator until interrupt or reset.
// - Power-save keeps asynchronous timer counting.
// - Noise-reduction keeps converter, asynchronous timer, interrupts and oscillator.
// - Standby keeps crystal oscillator running for fast wake.
// - Reset tri-states all port pins, clock or not.
// - Separate pull-up per bit; ports B, C, D are 8, 7, 8 wide.
// - Programmed fuse turns reset pin into I/O.
// - Unprogrammed fuse: low reset pin resets clocklessly.
// - RC clock plus select bit routes crystal pins.
module smp_ctrl
    import smp_pkg::*;
#(
    parameter int NPORT     = 3,
    parameter int WAKE_SLOW = `SMP_WAKE_SLOW_CYC,
    parameter int WAKE_FAST = `SMP_WAKE_FAST_CYC
)
(
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       we_i,
    input  wire logic       re_i,
    output logic      [7:0] rdata_o,
    input  wire logic       sleep_req_i,
    input  wire logic       wake_irq_i,
    input  wire logic       reset_pin_disable_fuse_i,
    input  wire logic       rc_clock_sel_i,
    input  wire logic [7:0] portb_pin_i,
    output logic      [7:0] portb_pin_o,
    output logic      [7:0] portb_oe_n_o,
    output logic      [7:0] portb_pull_en_o,
    input  wire logic [6:0] portc_pin_i,
    output logic      [6:0] portc_pin_o,
    output logic      [6:0] portc_oe_n_o,
    output logic      [6:0] portc_pull_en_o,
    input  wire logic [7:0] portd_pin_i,
    output logic      [7:0] portd_pin_o,
    output logic      [7:0] portd_oe_n_o,
    output logic      [7:0] portd_pull_en_o,
    output logic            sys_rst_n_o,
    output logic            timer_oscillator_pins_en_o,
    output logic            cpu_clk_en_o,
    output logic            mem_clk_en_o,
    output logic            timer_clk_en_o,
    output logic            spi_clk_en_o,
    output logic            irq_clk_en_o,
    output logic            adc_clk_en_o,
    output logic            async_timer_en_o,
    output logic            main_osc_en_o,
    output logic            io_clk_en_o,
    output logic            sleeping_o
);

    localparam int CW = 12;

    // Width of each port: B, C (with the shared reset bit), D.
    function automatic int port_w(input int p);
        port_w = (p == 1) ? 7 : 8;
    endfunction : port_w

    // Clock and unit enables held during each sleep mode.
    function automatic smp_gate_t mode_gate(input logic [2:0] m);
        smp_gate_t g;
        g = '0;
        unique case (m)
            `SMP_MODE_IDLE:
            begin
                g = '1;
                g[SMP_G_CPU] = 1'b0;
            end
            `SMP_MODE_ADC_NR:
            begin
                g[SMP_G_ADC]   = 1'b1;
                g[SMP_G_ASYNC] = 1'b1;
                g[SMP_G_IRQ]   = 1'b1;
                g[SMP_G_OSC]   = 1'b1;
            end
            `SMP_MODE_PWR_DOWN:
            begin
                g[SMP_G_IRQ] = 1'b1;
            end
            `SMP_MODE_PWR_SAVE:
            begin
                g[SMP_G_ASYNC] = 1'b1;
                g[SMP_G_IRQ]   = 1'b1;
            end
            `SMP_MODE_STANDBY:
            begin
                g[SMP_G_OSC] = 1'b1;
                g[SMP_G_IRQ] = 1'b1;
            end
            default:
            begin
                g = '1;
                g[SMP_G_CPU] = 1'b0;
            end
        endcase
        mode_gate = g;
    endfunction : mode_gate

    logic                core_rst_n;
    logic                xtal_routed;
    logic                wake_s;
    logic [NPORT-1:0][7:0] pin_in;
    logic [NPORT-1:0][7:0] pin_out;
    logic [NPORT-1:0][7:0] pin_oe_n;
    logic [NPORT-1:0][7:0] pin_pull;
    logic [NPORT-1:0][7:0] pin_rd;
    logic [NPORT-1:0][7:0] claim;

    logic [7:0]          sleep_ctrl_q;
    logic [7:0]          sleep_ctrl_d;
    logic                async_sel_q;
    logic                async_sel_d;
    logic [NPORT-1:0][7:0] out_q;
    logic [NPORT-1:0][7:0] out_d;
    logic [NPORT-1:0][7:0] dir_q;
    logic [NPORT-1:0][7:0] dir_d;
    logic [NPORT-1:0][7:0] pull_q;
    logic [NPORT-1:0][7:0] pull_d;
    logic [7:0]          rdata_q;
    logic [7:0]          rdata_d;

    smp_state_e          state_q;
    smp_state_e          state_d;
    smp_gate_t           gate_q;
    smp_gate_t           gate_d;
    logic [CW-1:0]       cnt_q;
    logic [CW-1:0]       cnt_d;

    // A low shared pin resets every flop asynchronously unless the fuse
    // has handed the pin to general I/O.
    assign core_rst_n = rst_n_i &
        (reset_pin_disable_fuse_i | portc_pin_i[`SMP_SHARED_RST_BIT]);
    assign sys_rst_n_o = core_rst_n;

    assign xtal_routed = rc_clock_sel_i & async_sel_q;
    assign timer_oscillator_pins_en_o = xtal_routed;

    smp_sync #(.W(1)) u_wake_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (core_rst_n),
        .ce_i    (ce_i),
        .d_i     (wake_irq_i),
        .q_o     (wake_s)
    );

    always_comb
    begin
        pin_in = '0;
        pin_in[0] = portb_pin_i;
        pin_in[1] = {1'b0, portc_pin_i};
        pin_in[2] = portd_pin_i;
        claim = '0;
        claim[0][`SMP_XTAL_HI_BIT] = xtal_routed;
        claim[0][`SMP_XTAL_LO_BIT] = xtal_routed;
        claim[1][`SMP_SHARED_RST_BIT] = ~reset_pin_disable_fuse_i;
    end

    genvar p;
    generate
        for (p = 0; p < NPORT; p = p + 1)
        begin : g_port
            localparam int PW = port_w(p);
            smp_port #(.W(PW)) u_port (
                .mclk_i     (mclk_i),
                .rst_n_i    (core_rst_n),
                .ce_i       (ce_i),
                .out_i      (out_q[p][PW-1:0]),
                .dir_i      (dir_q[p][PW-1:0]),
                .pull_i     (pull_q[p][PW-1:0]),
                .claim_i    (claim[p][PW-1:0]),
                .pin_i      (pin_in[p][PW-1:0]),
                .pin_o      (pin_out[p][PW-1:0]),
                .pin_oe_n_o (pin_oe_n[p][PW-1:0]),
                .pull_en_o  (pin_pull[p][PW-1:0]),
                .rd_o       (pin_rd[p][PW-1:0])
            );
            if (PW < 8)
            begin : g_pad
                assign pin_out[p][7:PW]  = '0;
                assign pin_oe_n[p][7:PW] = '1;
                assign pin_pull[p][7:PW] = '0;
                assign pin_rd[p][7:PW]   = '0;
            end
        end
    endgenerate

    assign portb_pin_o     = pin_out[0];
    assign portb_oe_n_o    = pin_oe_n[0];
    assign portb_pull_en_o = pin_pull[0];
    assign portc_pin_o     = pin_out[1][6:0];
    assign portc_oe_n_o    = pin_oe_n[1][6:0];
    assign portc_pull_en_o = pin_pull[1][6:0];
    assign portd_pin_o     = pin_out[2];
    assign portd_oe_n_o    = pin_oe_n[2];
    assign portd_pull_en_o = pin_pull[2];

    // Register file: writes, reads and the registered read data.
    always_comb
    begin
        logic [7:0] rel;
        logic [1:0] pidx;
        logic [1:0] sub;
        rel = addr_i - `SMP_OFF_PORT_BASE;
        pidx = rel[3:2];
        sub = rel[1:0];
        sleep_ctrl_d = sleep_ctrl_q;
        async_sel_d  = async_sel_q;
        out_d  = out_q;
        dir_d  = dir_q;
        pull_d = pull_q;
        rdata_d = 8'h00;
        if (ce_i && we_i)
        begin
            if (addr_i == `SMP_OFF_SLEEP_CTRL)
                sleep_ctrl_d = {4'h0, wdata_i[3:0]};
            else if (addr_i == `SMP_OFF_ASYNC_STAT)
                async_sel_d = wdata_i[`SMP_ASYNC_SEL_BIT];
            else if (addr_i >= `SMP_OFF_PORT_BASE && rel < 8'h0c)
            begin
                unique case (sub)
                    `SMP_SUB_OUT:  out_d[pidx]  = wdata_i;
                    `SMP_SUB_DIR:  dir_d[pidx]  = wdata_i;
                    `SMP_SUB_PIN:  out_d[pidx]  = out_q[pidx] ^ wdata_i;
                    `SMP_SUB_PULL: pull_d[pidx] = wdata_i;
                endcase
            end
        end
        if (ce_i && re_i)
        begin
            if (addr_i == `SMP_OFF_SLEEP_CTRL)
                rdata_d = sleep_ctrl_q;
            else if (addr_i == `SMP_OFF_ASYNC_STAT)
                rdata_d = {6'h00, xtal_routed, async_sel_q};
            else if (addr_i == `SMP_OFF_PWR_STAT)
                rdata_d = {gate_q[SMP_G_OSC:SMP_G_CPU]};
            else if (addr_i >= `SMP_OFF_PORT_BASE && rel < 8'h0c)
            begin
                unique case (sub)
                    `SMP_SUB_OUT:  rdata_d = out_q[pidx];
                    `SMP_SUB_DIR:  rdata_d = dir_q[pidx];
                    `SMP_SUB_PIN:  rdata_d = pin_rd[pidx];
                    `SMP_SUB_PULL: rdata_d = pull_q[pidx];
                endcase
            end
        end
        else if (!ce_i)
            rdata_d = rdata_q;
        out_d[1][7]  = 1'b0;
        dir_d[1][7]  = 1'b0;
        pull_d[1][7] = 1'b0;
    end

    // Sleep sequencer: enter on a sleep request, leave on a wake event.
    always_comb
    begin
        state_d = state_q;
        gate_d  = gate_q;
        cnt_d   = cnt_q;
        if (ce_i)
        begin
            unique case (state_q)
                SMP_ST_ACTIVE:
                begin
                    if (sleep_req_i && sleep_ctrl_q[`SMP_SLEEP_EN_BIT])
                    begin
                        state_d = SMP_ST_SLEEP;
                        gate_d  = mode_gate(sleep_ctrl_q[3:1]);
                    end
                end
                SMP_ST_SLEEP:
                begin
                    if (wake_s)
                    begin
                        state_d = SMP_ST_WAKE;
                        if (gate_q[SMP_G_OSC])
                            cnt_d = CW'(WAKE_FAST);
                        else
                            cnt_d = CW'(WAKE_SLOW);
                        gate_d[SMP_G_OSC] = 1'b1;
                    end
                end
                SMP_ST_WAKE:
                begin
                    if (cnt_q <= CW'(1))
                    begin
                        state_d = SMP_ST_ACTIVE;
                        gate_d  = '1;
                        cnt_d   = '0;
                    end
                    else
                        cnt_d = cnt_q - CW'(1);
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge core_rst_n)
    begin
        if (!core_rst_n)
        begin
            sleep_ctrl_q <= `SMP_RST_SLEEP_CTRL;
            async_sel_q  <= `SMP_RST_ASYNC_STAT;
            out_q        <= '0;
            dir_q        <= '0;
            pull_q       <= '0;
            rdata_q      <= '0;
            state_q      <= SMP_ST_ACTIVE;
            gate_q       <= '1;
            cnt_q        <= '0;
        end
        else
        begin
            sleep_ctrl_q <= sleep_ctrl_d;
            async_sel_q  <= async_sel_d;
            out_q        <= out_d;
            dir_q        <= dir_d;
            pull_q       <= pull_d;
            rdata_q      <= rdata_d;
            state_q      <= state_d;
            gate_q       <= gate_d;
            cnt_q        <= cnt_d;
        end
    end

    assign rdata_o          = rdata_q;
    assign cpu_clk_en_o     = gate_q[SMP_G_CPU];
    assign mem_clk_en_o     = gate_q[SMP_G_MEM];
    assign timer_clk_en_o   = gate_q[SMP_G_TIMER];
    assign spi_clk_en_o     = gate_q[SMP_G_SPI];
    assign irq_clk_en_o     = gate_q[SMP_G_IRQ];
    assign adc_clk_en_o     = gate_q[SMP_G_ADC];
    assign async_timer_en_o = gate_q[SMP_G_ASYNC];
    assign main_osc_en_o    = gate_q[SMP_G_OSC];
    assign io_clk_en_o      = gate_q[SMP_G_IO];
    assign sleeping_o       = (state_q != SMP_ST_ACTIVE);

endmodule : smp_ctrl

/* File: design/smp_regs.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef SMP_REGS_SVH
`define SMP_REGS_SVH

`define SMP_ADDR_W              8
`define SMP_DATA_W              8
`define SMP_OFF_SLEEP_CTRL      8'h00
`define SMP_OFF_ASYNC_STAT      8'h01
`define SMP_OFF_PWR_STAT        8'h02
`define SMP_OFF_PORT_BASE       8'h10
`define SMP_PORT_STRIDE         8'h04
`define SMP_SUB_OUT             2'h0
`define SMP_SUB_DIR             2'h1
`define SMP_SUB_PIN             2'h2
`define SMP_SUB_PULL            2'h3

`define SMP_SLEEP_EN_BIT        0
`define SMP_SLEEP_MODE_LSB      1
`define SMP_SLEEP_MODE_MSB      3
`define SMP_ASYNC_SEL_BIT       0
`define SMP_ASYNC_ROUTED_BIT    1

`define SMP_RST_SLEEP_CTRL      8'h00
`define SMP_RST_ASYNC_STAT      1'h0
`define SMP_RST_PORT            8'h00

`define SMP_MODE_IDLE           3'h0
`define SMP_MODE_ADC_NR         3'h1
`define SMP_MODE_PWR_DOWN       3'h2
`define SMP_MODE_PWR_SAVE       3'h3
`define SMP_MODE_STANDBY        3'h6

`define SMP_CLK_PERIOD_NS       4
`define SMP_WAKE_FAST_NS        24
`define SMP_WAKE_SLOW_NS        4000
`define SMP_WAKE_FAST_CYC       \
    ((`SMP_WAKE_FAST_NS + `SMP_CLK_PERIOD_NS - 1) / `SMP_CLK_PERIOD_NS)
`define SMP_WAKE_SLOW_CYC       \
    ((`SMP_WAKE_SLOW_NS + `SMP_CLK_PERIOD_NS - 1) / `SMP_CLK_PERIOD_NS)

`define SMP_XTAL_LO_BIT         6
`define SMP_XTAL_HI_BIT         7
`define SMP_SHARED_RST_BIT      6

`endif

/* File: design/smp_pkg.sv */
// Types shared by the sleep and reset-pin control block.
package smp_pkg;

    typedef enum logic [2:0] {
        SMP_ST_ACTIVE = 3'h1,
        SMP_ST_SLEEP  = 3'h2,
        SMP_ST_WAKE   = 3'h4
    } smp_state_e;

    typedef logic [8:0] smp_gate_t;

    localparam int SMP_G_CPU   = 0;
    localparam int SMP_G_MEM   = 1;
    localparam int SMP_G_TIMER = 2;
    localparam int SMP_G_SPI   = 3;
    localparam int SMP_G_IRQ   = 4;
    localparam int SMP_G_ADC   = 5;
    localparam int SMP_G_ASYNC = 6;
    localparam int SMP_G_OSC   = 7;
    localparam int SMP_G_IO    = 8;

endpackage : smp_pkg

/* File: design/smp_sync.sv */
// Two-flop synchroniser for inputs arriving from outside the clock domain.
module smp_sync
    import smp_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb
    begin
        meta_d = ce_i ? d_i : meta_q;
        sync_d = ce_i ? meta_q : sync_q;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q_o = sync_q;

endmodule : smp_sync

/* File: design/smp_port.sv */
// One bidirectional I/O port with per-bit pull-up and reset tri-state.
module smp_port
    import smp_pkg::*;
#(
    parameter int W = 8
)
(
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] out_i,
    input  wire logic [W-1:0] dir_i,
    input  wire logic [W-1:0] pull_i,
    input  wire logic [W-1:0] claim_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] pin_o,
    output logic      [W-1:0] pin_oe_n_o,
    output logic      [W-1:0] pull_en_o,
    output logic      [W-1:0] rd_o
);

    // The enable path is purely combinational from the reset net, so the
    // pins float at once even while no clock edge arrives.
    always_comb
    begin
        pin_o      = out_i;
        pin_oe_n_o = ~dir_i | claim_i | {W{~rst_n_i}};
        pull_en_o  = pull_i & ~dir_i & ~claim_i & {W{rst_n_i}};
    end

    smp_sync #(.W(W)) u_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .d_i     (pin_i),
        .q_o     (rd_o)
    );

endmodule : smp_port

/* File: tb/smp_ctrl_chk.sv */
// Checker for sleep gating, wake-up, reset pin and port pin behaviour.
module smp_ctrl_chk
    import smp_pkg::*;
(
    input wire logic       mclk_i,
    input wire logic       rst_n_i,
    input wire logic       reset_pin_disable_fuse_i,
    input wire logic       rc_clock_sel_i,
    input wire logic [6:0] portc_pin_i,
    input wire logic [7:0] portb_oe_n_o,
    input wire logic [6:0] portc_oe_n_o,
    input wire logic [7:0] portd_oe_n_o,
    input wire logic [7:0] portb_pull_en_o,
    input wire logic [6:0] portc_pull_en_o,
    input wire logic [7:0] portd_pull_en_o,
    input wire logic       sys_rst_n_o,
    input wire logic       timer_oscillator_pins_en_o,
    input wire logic       cpu_clk_en_o,
    input wire logic       mem_clk_en_o,
    input wire logic       timer_clk_en_o,
    input wire logic       spi_clk_en_o,
    input wire logic       irq_clk_en_o,
    input wire logic       adc_clk_en_o,
    input wire logic       async_timer_en_o,
    input wire logic       main_osc_en_o,
    input wire logic       io_clk_en_o,
    input wire logic       sleeping_o
);
    wire smp_gate_t gate = {io_clk_en_o, main_osc_en_o, async_timer_en_o,
        adc_clk_en_o, irq_clk_en_o, spi_clk_en_o, timer_clk_en_o,
        mem_clk_en_o, cpu_clk_en_o};

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_enter; !sleeping_o ##1 sleeping_o; endsequence
    sequence s_leave; sleeping_o ##1 !sleeping_o; endsequence
    sequence s_osc_up; sleeping_o && !main_osc_en_o ##1 main_osc_en_o;
    endsequence

    property p_cpu_halt; s_enter |-> !cpu_clk_en_o; endproperty
    a_cpu_halt: assert property (p_cpu_halt)
        else $error("processor clock runs while asleep");
    property p_mode_set;
        s_enter |-> gate inside {9'h1fe, 9'h0f0, 9'h010, 9'h050, 9'h090};
    endproperty
    a_mode_set: assert property (p_mode_set)
        else $error("sleep gate set is not one of the five modes");
    property p_wake_all; s_leave |-> gate == 9'h1ff; endproperty
    a_wake_all: assert property (p_wake_all)
        else $error("gates not all restored on wake");
    property p_slow_wake;
        s_osc_up |-> (!cpu_clk_en_o)[*2] ##[1:1000] cpu_clk_en_o;
    endproperty
    a_slow_wake: assert property (p_slow_wake)
        else $error("oscillator restart wait wrong");
    property p_pin_rst;
        !reset_pin_disable_fuse_i && !portc_pin_i[6] |->
            !sys_rst_n_o && &portb_oe_n_o && &portd_oe_n_o;
    endproperty
    a_pin_rst: assert property (p_pin_rst)
        else $error("reset pin low did not reset and float pins");
    property p_fuse_io; reset_pin_disable_fuse_i |-> sys_rst_n_o; endproperty
    a_fuse_io: assert property (p_fuse_io)
        else $error("reset from shared pin with fuse programmed");
    property p_rst_claim;
        !reset_pin_disable_fuse_i |->
            portc_oe_n_o[6] && !portc_pull_en_o[6];
    endproperty
    a_rst_claim: assert property (p_rst_claim)
        else $error("shared reset pin driven or pulled");
    property p_pull_in;
        (portb_pull_en_o & ~portb_oe_n_o) == 8'h00 &&
        (portc_pull_en_o & ~portc_oe_n_o) == 7'h00 &&
        (portd_pull_en_o & ~portd_oe_n_o) == 8'h00;
    endproperty
    a_pull_in: assert property (p_pull_in)
        else $error("pull-up on a driven bit");
    property p_xtal;
        timer_oscillator_pins_en_o |-> rc_clock_sel_i && &portb_oe_n_o[7:6];
    endproperty
    a_xtal: assert property (p_xtal)
        else $error("crystal pins routed without rc clock or still driven");
endmodule : smp_ctrl_chk

/* File: tb/test_smp_ctrl.sv */
// Self-checking bench for the sleep and reset-pin control block.
`include "smp_regs.svh"
module test_smp_ctrl
    import smp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic       mclk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       ce_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic       we_i = 1'b0;
    logic       re_i = 1'b0;
    logic       sleep_req_i = 1'b0;
    logic       wake_irq_i = 1'b0;
    logic       fuse = 1'b0;
    logic       rc_sel = 1'b0;
    logic [7:0] pb_in = 8'hc3;
    logic [6:0] pc_in = 7'h43;
    logic [7:0] pd_in = 8'hc3;
    wire  [7:0] rdata_o, pb_out, pb_oe_n, pb_pull, pd_out, pd_oe_n, pd_pull;
    wire  [6:0] pc_out, pc_oe_n, pc_pull;
    wire        sys_rst_n, tosc_en, sleeping;
    wire smp_gate_t gate;
    int         n_fail = 0;
    int         checks = 0;
    int         cyc = 0;

    smp_ctrl #(.WAKE_SLOW(12), .WAKE_FAST(3)) uut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
        .sleep_req_i(sleep_req_i), .wake_irq_i(wake_irq_i),
        .reset_pin_disable_fuse_i(fuse), .rc_clock_sel_i(rc_sel),
        .portb_pin_i(pb_in), .portb_pin_o(pb_out), .portb_oe_n_o(pb_oe_n),
        .portb_pull_en_o(pb_pull), .portc_pin_i(pc_in), .portc_pin_o(pc_out),
        .portc_oe_n_o(pc_oe_n), .portc_pull_en_o(pc_pull),
        .portd_pin_i(pd_in), .portd_pin_o(pd_out), .portd_oe_n_o(pd_oe_n),
        .portd_pull_en_o(pd_pull), .sys_rst_n_o(sys_rst_n),
        .timer_oscillator_pins_en_o(tosc_en), .cpu_clk_en_o(gate[0]),
        .mem_clk_en_o(gate[1]), .timer_clk_en_o(gate[2]),
        .spi_clk_en_o(gate[3]), .irq_clk_en_o(gate[4]), .adc_clk_en_o(gate[5]),
        .async_timer_en_o(gate[6]), .main_osc_en_o(gate[7]),
        .io_clk_en_o(gate[8]), .sleeping_o(sleeping));

    always #2 mclk_i = ~mclk_i;

    task automatic print_verdict();
        if (n_fail == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [8:0] e,
                       input logic [8:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    function automatic logic [8:0] pick(input int p, input logic [7:0] b,
                                        input logic [6:0] c,
                                        input logic [7:0] d);
        return (p == 0) ? {1'b0, b} : (p == 1) ? {2'b00, c} : {1'b0, d};
    endfunction : pick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        we_i    <= 1'b1;
        @(posedge mclk_i);
        we_i <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        addr_i <= a;
        re_i   <= 1'b1;
        @(posedge mclk_i);
        re_i <= 1'b0;
        #1;
        chk($sformatf("rdata %h", a), {1'b0, e}, {1'b0, rdata_o});
    endtask : rd

    task automatic t_reset_vals();
        rd(8'h00, 8'h00);
        rd(8'h01, 8'h00);
        rd(8'h02, 8'hff);
        rd(8'h0f, 8'h00);
        for (int p = 0; p < 3; p++)
        begin
            rd(8'h10 + 8'(4 * p), 8'h00);
            rd(8'h11 + 8'(4 * p), 8'h00);
            rd(8'h13 + 8'(4 * p), 8'h00);
        end
    endtask : t_reset_vals

    task automatic t_ports();
        logic [7:0] b;
        logic [8:0] m;
        fuse <= 1'b1;
        for (int p = 0; p < 3; p++)
        begin
            b = 8'h10 + 8'(4 * p);
            m = (p == 1) ? 9'h07f : 9'h0ff;
            wr(b + 8'h01, 8'h0f);
            wr(b, 8'ha5);
            wr(b + 8'h03, 8'hff);
            chk("oe_n", 9'h0f0 & m, pick(p, pb_oe_n, pc_oe_n, pd_oe_n));
            chk("pin_o", 9'h0a5 & m, pick(p, pb_out, pc_out, pd_out));
            chk("pull", 9'h0f0 & m, pick(p, pb_pull, pc_pull, pd_pull));
            wr(b + 8'h02, 8'h01);
            chk("toggle", 9'h0a4 & m, pick(p, pb_out, pc_out, pd_out));
            rd(b + 8'h02, 8'hc3 & m[7:0]);
            wr(b + 8'h01, 8'h00);
            wr(b + 8'h03, 8'h00);
        end
        fuse <= 1'b0;
    endtask : t_ports

    task automatic t_modes();
        // Code 7 is reserved and must fall back to the idle gate set.
        logic [2:0] code [6] = '{`SMP_MODE_IDLE, `SMP_MODE_ADC_NR,
            `SMP_MODE_PWR_DOWN, `SMP_MODE_PWR_SAVE, `SMP_MODE_STANDBY,
            3'h7};
        logic [8:0] exp [6] = '{9'h1fe, 9'h0f0, 9'h010, 9'h050, 9'h090,
            9'h1fe};
        int k;
        wr(8'h00, 8'h00);
        @(posedge mclk_i);
        sleep_req_i <= 1'b1;
        @(posedge mclk_i);
        sleep_req_i <= 1'b0;
        #1;
        chk("refused sleep", 9'h000, {8'h00, sleeping});
        for (int i = 0; i < 6; i++)
        begin
            wr(8'h00, {4'h0, code[i], 1'b1});
            @(posedge mclk_i);
            sleep_req_i <= 1'b1;
            @(posedge mclk_i);
            sleep_req_i <= 1'b0;
            #1;
            chk("gates", exp[i], gate);
            repeat (20) @(posedge mclk_i);
            chk("asleep", 9'h001, {8'h00, sleeping});
            wake_irq_i <= 1'b1;
            k = 0;
            while (sleeping !== 1'b0 && k < 100)
            begin
                @(posedge mclk_i);
                #1;
                k++;
            end
            chk("woken gates", 9'h1ff, gate);
            chk("wake cycles", exp[i][7] ? 9'h006 : 9'h00f, 9'(k));
            @(posedge mclk_i);
            wake_irq_i <= 1'b0;
            repeat (4) @(posedge mclk_i);
            rd(8'h02, 8'hff);
        end
    endtask : t_modes

    task automatic t_xtal();
        wr(8'h11, 8'hff);
        rc_sel <= 1'b1;
        wr(8'h01, 8'h01);
        chk("tosc", 9'h001, {8'h00, tosc_en});
        chk("xtal oe_n", 9'h0c0, {1'b0, pb_oe_n});
        rd(8'h01, 8'h03);
        @(posedge mclk_i);
        rc_sel <= 1'b0;
        #1;
        chk("tosc off", 9'h000, {8'h00, tosc_en});
        chk("xtal back", 9'h000, {1'b0, pb_oe_n});
        wr(8'h01, 8'h00);
    endtask : t_xtal

    task automatic t_pin_rst();
        @(posedge mclk_i);
        pc_in[6] <= 1'b0;
        #1;
        chk("sys_rst_n", 9'h000, {8'h00, sys_rst_n});
        chk("float", 9'h0ff, {1'b0, pb_oe_n});
        repeat (2) @(posedge mclk_i);
        pc_in[6] <= 1'b1;
        rd(8'h11, 8'h00);
        @(posedge mclk_i);
        fuse <= 1'b1;
        @(posedge mclk_i);
        pc_in[6] <= 1'b0;
        wr(8'h15, 8'h40);
        wr(8'h14, 8'h40);
        chk("io sys_rst_n", 9'h001, {8'h00, sys_rst_n});
        chk("io oe_n", 9'h03f, {2'b00, pc_oe_n});
        chk("io out", 9'h040, {2'b00, pc_out});
        wr(8'h15, 8'h00);
        pc_in[6] <= 1'b1;
        @(posedge mclk_i);
        fuse <= 1'b0;
    endtask : t_pin_rst

    task automatic t_ce();
        @(posedge mclk_i);
        ce_i <= 1'b0;
        wr(8'h10, 8'h5a);
        chk("frozen out", 9'h000, {1'b0, pb_out});
        @(posedge mclk_i);
        ce_i <= 1'b1;
        rd(8'h10, 8'h00);
    endtask : t_ce

    initial
    begin
        repeat (10) @(posedge mclk_i);
        chk("rst oe_b", 9'h0ff, {1'b0, pb_oe_n});
        chk("rst oe_c", 9'h07f, {2'b00, pc_oe_n});
        chk("rst oe_d", 9'h0ff, {1'b0, pd_oe_n});
        rst_n_i <= 1'b1;
        t_reset_vals();
        t_ports();
        t_modes();
        t_xtal();
        t_pin_rst();
        t_ce();
        print_verdict();
    end
endmodule : test_smp_ctrl

bind smp_ctrl smp_ctrl_chk u_chk (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .reset_pin_disable_fuse_i(reset_pin_disable_fuse_i),
    .rc_clock_sel_i(rc_clock_sel_i), .portc_pin_i(portc_pin_i),
    .portb_oe_n_o(portb_oe_n_o), .portc_oe_n_o(portc_oe_n_o),
    .portd_oe_n_o(portd_oe_n_o), .portb_pull_en_o(portb_pull_en_o),
    .portc_pull_en_o(portc_pull_en_o), .portd_pull_en_o(portd_pull_en_o),
    .sys_rst_n_o(sys_rst_n_o),
    .timer_oscillator_pins_en_o(timer_oscillator_pins_en_o),
    .cpu_clk_en_o(cpu_clk_en_o), .mem_clk_en_o(mem_clk_en_o),
    .timer_clk_en_o(timer_clk_en_o), .spi_clk_en_o(spi_clk_en_o),
    .irq_clk_en_o(irq_clk_en_o), .adc_clk_en_o(adc_clk_en_o),
    .async_timer_en_o(async_timer_en_o), .main_osc_en_o(main_osc_en_o),
    .io_clk_en_o(io_clk_en_o), .sleeping_o(sleeping_o));
